// File: exec_defs.svh
// Register offsets, field positions, reset values and cycle counts
// of the execute unit. Included by the unit and by its bench.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define ADDR_CTRL 8'h00
`define ADDR_OPND 8'h04
`define ADDR_FLAGS 8'h08
`define ADDR_PC 8'h0C
`define ADDR_ZPTR 8'h10
`define ADDR_IOVAL 8'h14
`define ADDR_RESULT 8'h18
`define ADDR_STATUS 8'h1C
`define ADDR_RETADDR 8'h20
`define ADDR_DATA_LO 8'h24
`define ADDR_DATA_HI 8'h28
`define ADDR_KEY_LO 8'h2C
`define ADDR_KEY_HI 8'h30
// CTRL fields
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 4
`define CTRL_START 5
`define CTRL_BIT_LSB 6
`define CTRL_BIT_MSB 8
`define CTRL_FLAG_LSB 9
`define CTRL_FLAG_MSB 11
`define CTRL_TWO_WORD 12
`define CTRL_PC22 13
// Status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_I 7
// Reset values
`define RST_CTRL 14'h0000
`define RST_WORD 32'h00000000
`define RST_FLAGS 8'h00
`define RST_PC 22'h000000
// Cycle counts
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2
`define CYC_THREE 4'h3
`define CYC_FOUR 4'h4
`endif

// File: exec_pkg.sv
// Types shared by the execute unit: operation codes and result record.
// Holds types only; the numeric constants live in exec_defs.svh.
package exec_pkg;
  typedef enum logic [4:0] {
    test_zero_or_negative_op, set_bits_op, clear_bits_op,
    unsigned_multiply_op, signed_multiply_op, mixed_sign_multiply,
    fractional_unsigned_multiply, fractional_signed_multiply,
    fractional_mixed_multiply, data_cipher_op, indirect_jump_op,
    extended_indirect_jump_op, indirect_call_op, extended_indirect_call_op,
    compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op, branch_flag_set_op,
    branch_flag_clear_op, branch_signed_ge_op, branch_signed_lt_op,
    branch_unsigned_ge_op, branch_unsigned_lt_op, branch_half_carry_set_op,
    branch_half_carry_clear_op, branch_overflow_set_op,
    branch_overflow_clear_op, branch_irq_enabled_op, branch_irq_disabled_op
  } op_t;

  typedef struct packed {
    logic [15:0] result;
    logic [7:0] flags;
    logic [21:0] pc;
    logic [21:0] ret;
    logic [63:0] data;
    logic [3:0] cycles;
    logic taken;
    logic [1:0] pushed;
  } exec_res_t;
endpackage : exec_pkg

// File: exec_unit.sv
// Execute unit for logic tail, multiplies, cipher step, indirect jumps
// and calls, skips and conditional branches, reached over APB.
// Assumes an APB master on clk_i; one operation runs at a time.
`timescale 1ns/10ps
`include "exec_defs.svh"

module exec_unit
  import exec_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i, // 40 MHz core clock
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction, high is write
  input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  output logic busy_o, // operation in progress
  output logic flush_o // one-cycle pulse: drop fetched instruction
);
  logic [13:0] ctrl;
  logic [22:0] opnd;
  logic [7:0] flags;
  logic [21:0] pc;
  logic [23:0] zptr;
  logic [7:0] ioval;
  logic [15:0] result;
  logic [21:0] retaddr;
  logic [63:0] data;
  logic [63:0] key;
  logic [3:0] cycles;
  logic [3:0] cnt;
  logic taken;
  logic [1:0] pushed;
  logic last_cipher;
  exec_res_t next_res;

  // Bus decode
  wire [7:0] addr = 8'(paddr_i);
  wire access = psel_i && penable_i;
  wire commit = access && pready_o;
  wire wr = commit && pwrite_i;
  wire hit = addr == `ADDR_CTRL || addr == `ADDR_OPND ||
    addr == `ADDR_FLAGS || addr == `ADDR_PC || addr == `ADDR_ZPTR ||
    addr == `ADDR_IOVAL || addr == `ADDR_RESULT ||
    addr == `ADDR_STATUS || addr == `ADDR_RETADDR ||
    addr == `ADDR_DATA_LO || addr == `ADDR_DATA_HI ||
    addr == `ADDR_KEY_LO || addr == `ADDR_KEY_HI;
  wire start = wr && addr == `ADDR_CTRL && pwdata_i[`CTRL_START] && !busy_o;
  wire [31:0] status_word = {23'h000000, pushed, flush_o, taken,
    cycles, busy_o};
  wire [31:0] rd_data =
    addr == `ADDR_CTRL ? {18'h00000, ctrl} :
    addr == `ADDR_OPND ? {9'h000, opnd} :
    addr == `ADDR_FLAGS ? {24'h000000, flags} :
    addr == `ADDR_PC ? {10'h000, pc} :
    addr == `ADDR_ZPTR ? {8'h00, zptr} :
    addr == `ADDR_IOVAL ? {24'h000000, ioval} :
    addr == `ADDR_RESULT ? {16'h0000, result} :
    addr == `ADDR_STATUS ? status_word :
    addr == `ADDR_RETADDR ? {10'h000, retaddr} :
    addr == `ADDR_DATA_LO ? data[31:0] :
    addr == `ADDR_DATA_HI ? data[63:32] :
    addr == `ADDR_KEY_LO ? key[31:0] :
    addr == `ADDR_KEY_HI ? key[63:32] : 32'h00000000;

  // Operation fields, taken from the CTRL write that starts the op; operands come from the OPND register
  wire [13:0] new_ctrl = 14'(pwdata_i);
  op_t op;
  assign op = op_t'(new_ctrl[`CTRL_OP_MSB:`CTRL_OP_LSB]);
  wire [2:0] bit_sel = new_ctrl[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
  wire [2:0] flag_sel = new_ctrl[`CTRL_FLAG_MSB:`CTRL_FLAG_LSB];
  wire two_word = new_ctrl[`CTRL_TWO_WORD];
  wire pc22 = new_ctrl[`CTRL_PC22];
  wire [7:0] rd_v = opnd[7:0];
  wire [7:0] rr_v = opnd[15:8];
  wire [6:0] rel_k = opnd[22:16];
  wire [3:0] cipher_k = rd_v[3:0];

  // Arithmetic helpers
  wire [15:0] rd_sx = {{8{rd_v[7]}}, rd_v};
  wire [15:0] rr_sx = {{8{rr_v[7]}}, rr_v};
  wire [15:0] prod_uu = 16'({8'h00, rd_v} * {8'h00, rr_v});
  wire [15:0] prod_ss = 16'(rd_sx * rr_sx);
  wire [15:0] prod_su = 16'(rd_sx * {8'h00, rr_v});
  wire [21:0] pc_inc = pc + 22'h000001;
  wire [21:0] pc_rel = pc_inc + {{15{rel_k[6]}}, rel_k};
  wire [21:0] pc_skip = pc + (two_word ? 22'h000003 : 22'h000002);
  wire [3:0] skip_cyc = two_word ? `CYC_THREE : `CYC_TWO;
  wire [63:0] key_mix = key ^ {16{cipher_k}};
  wire [63:0] enc_data = {data[62:0], data[63]} ^ key_mix;
  wire [63:0] dec_tmp = data ^ key_mix;
  wire [63:0] dec_data = {dec_tmp[0], dec_tmp[63:1]};
  wire f_c = flags[`FLAG_C];
  wire f_h = flags[`FLAG_H];
  wire f_v = flags[`FLAG_V];
  wire f_i = flags[`FLAG_I];
  wire f_nv = flags[`FLAG_N] ^ flags[`FLAG_V];

  function automatic logic [7:0] logic_flags(input logic [7:0] f,
                                             input logic [7:0] v);
    logic [7:0] o;
    o = f;
    o[`FLAG_Z] = v == 8'h00;
    o[`FLAG_N] = v[7];
    o[`FLAG_V] = 1'b0;
    o[`FLAG_S] = v[7];
    return o;
  endfunction : logic_flags

  function automatic logic [7:0] mul_flags(input logic [7:0] f,
                                           input logic [15:0] p,
                                           input logic [15:0] r);
    logic [7:0] o;
    o = f;
    o[`FLAG_C] = p[15];
    o[`FLAG_Z] = r == 16'h0000;
    return o;
  endfunction : mul_flags

  // Branch condition and kind
  logic br_cond;
  logic is_branch;
  logic skip_cond;
  logic is_skip;
  always_comb begin
    br_cond = 1'b0;
    is_branch = 1'b1;
    skip_cond = 1'b0;
    is_skip = 1'b1;
    case (op)
      branch_flag_set_op: br_cond = flags[flag_sel];
      branch_flag_clear_op: br_cond = !flags[flag_sel];
      branch_signed_ge_op: br_cond = !f_nv;
      branch_signed_lt_op: br_cond = f_nv;
      branch_unsigned_ge_op: br_cond = !f_c;
      branch_unsigned_lt_op: br_cond = f_c;
      branch_half_carry_set_op: br_cond = f_h;
      branch_half_carry_clear_op: br_cond = !f_h;
      branch_overflow_set_op: br_cond = f_v;
      branch_overflow_clear_op: br_cond = !f_v;
      branch_irq_enabled_op: br_cond = f_i;
      branch_irq_disabled_op: br_cond = !f_i;
      default: is_branch = 1'b0;
    endcase
    case (op)
      compare_skip_equal_op: skip_cond = rd_v == rr_v;
      skip_reg_bit_clear_op: skip_cond = !rr_v[bit_sel];
      skip_reg_bit_set_op: skip_cond = rr_v[bit_sel];
      skip_io_bit_clear_op: skip_cond = !ioval[bit_sel];
      skip_io_bit_set_op: skip_cond = ioval[bit_sel];
      default: is_skip = 1'b0;
    endcase
  end

  wire io_skip = op == skip_io_bit_clear_op || op == skip_io_bit_set_op;

  // Result of the operation being started
  always_comb begin
    next_res = '0;
    next_res.result = result;
    next_res.flags = flags;
    next_res.pc = pc_inc;
    next_res.ret = retaddr;
    next_res.data = data;
    next_res.cycles = `CYC_ONE;
    if (is_branch) begin
      next_res.taken = br_cond;
      next_res.pc = br_cond ? pc_rel : pc_inc;
      next_res.cycles = br_cond ? `CYC_TWO : `CYC_ONE;
    end else if (is_skip) begin
      next_res.taken = skip_cond;
      next_res.pc = skip_cond ? pc_skip : pc_inc;
      next_res.cycles = skip_cond ? skip_cyc : `CYC_ONE;
      if (io_skip) begin
        next_res.cycles = 4'(next_res.cycles + `CYC_ONE);
      end
    end else begin
      case (op)
        test_zero_or_negative_op: begin
          next_res.result = {8'h00, rd_v & rd_v};
          next_res.flags = logic_flags(flags, rd_v & rd_v);
        end
        set_bits_op: begin
          next_res.result = {8'h00, rd_v | rr_v};
          next_res.flags = logic_flags(flags, rd_v | rr_v);
        end
        clear_bits_op: begin
          next_res.result = {8'h00, rd_v & ~rr_v};
          next_res.flags = logic_flags(flags, rd_v & ~rr_v);
        end
        unsigned_multiply_op: begin
          next_res.result = prod_uu;
          next_res.flags = mul_flags(flags, prod_uu, prod_uu);
          next_res.cycles = `CYC_TWO;
        end
        signed_multiply_op: begin
          next_res.result = prod_ss;
          next_res.flags = mul_flags(flags, prod_ss, prod_ss);
          next_res.cycles = `CYC_TWO;
        end
        mixed_sign_multiply: begin
          next_res.result = prod_su;
          next_res.flags = mul_flags(flags, prod_su, prod_su);
          next_res.cycles = `CYC_TWO;
        end
        fractional_unsigned_multiply: begin
          next_res.result = {prod_uu[14:0], 1'b0};
          next_res.flags = mul_flags(flags, prod_uu, {prod_uu[14:0], 1'b0});
          next_res.cycles = `CYC_TWO;
        end
        fractional_signed_multiply: begin
          next_res.result = {prod_ss[14:0], 1'b0};
          next_res.flags = mul_flags(flags, prod_ss, {prod_ss[14:0], 1'b0});
          next_res.cycles = `CYC_TWO;
        end
        fractional_mixed_multiply: begin
          next_res.result = {prod_su[14:0], 1'b0};
          next_res.flags = mul_flags(flags, prod_su, {prod_su[14:0], 1'b0});
          next_res.cycles = `CYC_TWO;
        end
        data_cipher_op: begin
          next_res.data = f_h ? dec_data : enc_data;
          next_res.cycles = last_cipher ? `CYC_ONE : `CYC_TWO;
        end
        indirect_jump_op: begin
          next_res.pc = {6'h00, zptr[15:0]};
          next_res.cycles = `CYC_TWO;
        end
        extended_indirect_jump_op: begin
          next_res.pc = {zptr[21:16], zptr[15:0]};
          next_res.cycles = `CYC_TWO;
        end
        // third stacked byte adds a cycle
        indirect_call_op: begin
          next_res.pc = {6'h00, zptr[15:0]};
          next_res.ret = pc_inc;
          next_res.pushed = pc22 ? 2'h3 : 2'h2;
          next_res.cycles = pc22 ? `CYC_THREE : `CYC_TWO;
        end
        extended_indirect_call_op: begin
          next_res.pc = {zptr[21:16], zptr[15:0]};
          next_res.ret = pc_inc;
          next_res.pushed = pc22 ? 2'h3 : 2'h2;
          next_res.cycles = `CYC_THREE;
        end
        default: next_res.cycles = `CYC_ONE;
      endcase
    end
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= `RST_WORD;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access && !pready_o;
      prdata_o <= (access && !pready_o && !pwrite_i) ? rd_data : `RST_WORD;
      pslverr_o <= access && !pready_o && !hit;
    end
  end

  // Software writable registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `RST_CTRL;
      opnd <= 23'h000000;
      zptr <= 24'h000000;
      ioval <= 8'h00;
      key <= 64'h0000000000000000;
    end else if (wr) begin
      if (addr == `ADDR_CTRL && !busy_o) ctrl <= new_ctrl;
      if (addr == `ADDR_OPND) opnd <= 23'(pwdata_i);
      if (addr == `ADDR_ZPTR) zptr <= 24'(pwdata_i);
      if (addr == `ADDR_IOVAL) ioval <= 8'(pwdata_i);
      if (addr == `ADDR_KEY_LO) key[31:0] <= pwdata_i;
      if (addr == `ADDR_KEY_HI) key[63:32] <= pwdata_i;
    end
  end

  // Architectural state: the started operation wins over software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= `RST_FLAGS;
      pc <= `RST_PC;
      result <= 16'h0000;
      retaddr <= `RST_PC;
      data <= 64'h0000000000000000;
    end else if (start) begin
      flags <= next_res.flags;
      pc <= next_res.pc;
      result <= next_res.result;
      retaddr <= next_res.ret;
      data <= next_res.data;
    end else if (wr) begin
      if (addr == `ADDR_FLAGS) flags <= 8'(pwdata_i);
      if (addr == `ADDR_PC) pc <= 22'(pwdata_i);
      if (addr == `ADDR_DATA_LO) data[31:0] <= pwdata_i;
      if (addr == `ADDR_DATA_HI) data[63:32] <= pwdata_i;
    end
  end

  // Cycle accounting and fetch flush
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      cnt <= 4'h0;
      cycles <= 4'h0;
      taken <= 1'b0;
      pushed <= 2'h0;
      last_cipher <= 1'b0;
      flush_o <= 1'b0;
    end else begin
      flush_o <= start && next_res.taken;
      if (start) begin
        busy_o <= 1'b1;
        cnt <= 4'(next_res.cycles - `CYC_ONE);
        cycles <= next_res.cycles;
        taken <= next_res.taken;
        pushed <= next_res.pushed;
        last_cipher <= op == data_cipher_op;
      end else if (cnt != 4'h0) begin
        cnt <= 4'(cnt - 4'h1);
      end else begin
        busy_o <= 1'b0;
      end
    end
  end

  sequence s_two_busy;
    busy_o ##1 busy_o ##1 !busy_o;
  endsequence
  sequence s_three_busy;
    busy_o [*3] ##1 !busy_o;
  endsequence

  a_logic_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op inside {test_zero_or_negative_op, set_bits_op, clear_bits_op}
    |=> !flags[`FLAG_V] && flags[`FLAG_S] == flags[`FLAG_N] &&
        flags[`FLAG_Z] == (result[7:0] == 8'h00) && cycles == `CYC_ONE)
    else $error("logic op flags or length wrong");
  a_set_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == set_bits_op |=>
    result[7:0] == ($past(opnd[7:0]) | $past(opnd[15:8])))
    else $error("set bits result wrong");
  a_clear_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == clear_bits_op |=>
    result[7:0] == ($past(opnd[7:0]) & ~$past(opnd[15:8])))
    else $error("clear bits result wrong");
  a_mixed_mul: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == mixed_sign_multiply |=> result == $past(prod_su) &&
    flags[`FLAG_C] == result[15] ##0 s_two_busy)
    else $error("mixed multiply wrong");
  a_frac_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == fractional_unsigned_multiply |=>
    result == {$past(prod_uu[14:0]), 1'b0} && cycles == `CYC_TWO)
    else $error("fractional multiply not shifted");
  a_cipher_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == data_cipher_op |=>
    data == ($past(f_h) ? $past(dec_data) : $past(enc_data)))
    else $error("cipher direction wrong");
  a_indirect_jump_op_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == indirect_jump_op |=>
    pc == {6'h00, $past(zptr[15:0])} ##0 s_two_busy)
    else $error("indirect jump target wrong");
  a_ext_call: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && op == extended_indirect_call_op |=>
    pc[21:16] == $past(zptr[21:16]) && retaddr == $past(pc_inc)
    ##0 s_three_busy)
    else $error("extended call wrong");
  a_skip_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && is_skip && skip_cond |=> flush_o &&
    pc == $past(pc) + ($past(two_word) ? 22'h000003 : 22'h000002))
    else $error("skip target wrong");
  a_io_cycles: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && io_skip && !skip_cond |=> cycles == `CYC_TWO ##0 s_two_busy)
    else $error("io skip length wrong");
  a_branch_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start && is_branch |=> flags == $past(flags) &&
    cycles == ($past(br_cond) ? `CYC_TWO : `CYC_ONE) &&
    pc == ($past(br_cond) ? $past(pc_rel) : $past(pc_inc)))
    else $error("branch outcome wrong");
endmodule : exec_unit

// File: test_cpu_alu_branch_execute.sv
// Self-checking bench for the execute unit, driven over APB.
// Assumes exec_pkg, exec_defs.svh and exec_unit are compiled first.
`timescale 1ns/10ps
`include "exec_defs.svh"
module test_cpu_alu_branch_execute;
  import exec_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, busy, flush, sl;
  logic [7:0] paddr = 8'h00, nb = 8'h00, nf = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  int err_count = 0, n_tests = 0;

  exec_unit i_exec_unit (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .busy_o(busy), .flush_o(flush));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Counts busy and flush cycles mid-cycle, where both have settled
  always @(negedge clk_i) begin
    nb = nb + 8'(busy);
    nf = nf + 8'(flush);
  end

  task finish_test;
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    // Answer is watched mid-cycle; the request stands to the next edge
    do begin
      @(negedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 32'h0, 32'h1);
    q = prdata;
    sl = pslverr;
    @(posedge clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : ax

  // Starts one operation from PC 0x100 and judges timing, and PC for jumps, calls, skips and branches
  task run(input op_t op, input logic [7:0] x, input logic [31:0] od,
      input logic [7:0] fl, input logic [21:0] epc, input logic [3:0] ec,
      input logic et);
    ax(1'b1, `ADDR_FLAGS, {24'h0, fl});
    ax(1'b1, `ADDR_OPND, od);
    ax(1'b1, `ADDR_PC, 32'h100);
    nb = 8'h00;
    nf = 8'h00;
    ax(1'b1, `ADDR_CTRL, {18'h0, x, 1'b1, op});
    repeat (6) @(posedge clk_i);
    ax(1'b0, `ADDR_STATUS, 32'h0);
    chk("cycles", {28'h0, q[4:1]}, {28'h0, ec});
    chk("busy_len", {24'h0, nb}, {28'h0, ec});
    if (op >= compare_skip_equal_op) begin
      chk("taken", {31'h0, q[5]}, {31'h0, et});
      chk("flush_n", {24'h0, nf}, {31'h0, et});
    end
    if (op >= indirect_jump_op) begin
      ax(1'b0, `ADDR_PC, 32'h0);
      chk("pc", q, {10'h0, epc});
      ax(1'b0, `ADDR_FLAGS, 32'h0);
      chk("flags_kept", q, {24'h0, fl});
    end
  endtask : run

  task res(input logic [15:0] er, input logic [7:0] ef);
    ax(1'b0, `ADDR_RESULT, 32'h0);
    chk("result", {16'h0, q[15:0]}, {16'h0, er});
    ax(1'b0, `ADDR_FLAGS, 32'h0);
    chk("flags", q, {24'h0, ef});
  endtask : res

  task t_reset_map;
    ax(1'b0, `ADDR_PC, 32'h0);
    chk("pc_reset", q, 32'h00000000);
    ax(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", {31'h0, sl}, 32'h1);
    chk("unmapped_data", q, 32'h0);
  endtask : t_reset_map

  task t_alu;
    run(test_zero_or_negative_op, 8'h00, 32'h80, 8'h00, 0, 4'h1, 0);
    res(16'h0080, 8'h14);
    run(test_zero_or_negative_op, 8'h00, 32'h00, 8'h08, 0, 4'h1, 0);
    res(16'h0000, 8'h02);
    run(set_bits_op, 8'h00, 32'h700F, 8'h00, 0, 4'h1, 0);
    res(16'h007F, 8'h00);
    run(clear_bits_op, 8'h00, 32'h0FFF, 8'h00, 0, 4'h1, 0);
    res(16'h00F0, 8'h14);
    run(mixed_sign_multiply, 8'h00, 32'h02FF, 8'h40, 0, 4'h2, 0);
    res(16'hFFFE, 8'h41);
    run(unsigned_multiply_op, 8'h00, 32'h00FF, 8'h40, 0, 4'h2, 0);
    res(16'h0000, 8'h42);
    run(signed_multiply_op, 8'h00, 32'h02FF, 8'h40, 0, 4'h2, 0);
    res(16'hFFFE, 8'h41);
    run(fractional_unsigned_multiply, 8'h00, 32'h8080, 8'h40, 0, 4'h2, 0);
    res(16'h8000, 8'h40);
    run(fractional_signed_multiply, 8'h00, 32'h8080, 8'h40, 0, 4'h2, 0);
    res(16'h8000, 8'h40);
    run(fractional_mixed_multiply, 8'h00, 32'h8080, 8'h40, 0, 4'h2, 0);
    res(16'h8000, 8'h41);
  endtask : t_alu

  task t_cipher;
    ax(1'b1, `ADDR_DATA_LO, 32'h1);
    ax(1'b1, `ADDR_DATA_HI, 32'h0);
    ax(1'b1, `ADDR_KEY_LO, 32'h100);
    ax(1'b0, `ADDR_KEY_LO, 32'h0);
    chk("key_lo", q, 32'h00000100);
    run(data_cipher_op, 8'h00, 32'h01, 8'h00, 0, 4'h2, 0);
    ax(1'b0, `ADDR_DATA_LO, 32'h0);
    chk("enc_lo", q, 32'h11111013);
    run(data_cipher_op, 8'h00, 32'h01, 8'h20, 0, 4'h1, 0);
    ax(1'b0, `ADDR_DATA_LO, 32'h0);
    chk("dec_lo", q, 32'h00000001);
    ax(1'b0, `ADDR_DATA_HI, 32'h0);
    chk("dec_hi", q, 32'h00000000);
  endtask : t_cipher

  task t_jump_skip;
    ax(1'b1, `ADDR_ZPTR, 32'h151234);
    ax(1'b1, `ADDR_IOVAL, 32'h80);
    run(indirect_jump_op, 8'h00, 0, 8'h00, 22'h001234, 4'h2, 0);
    run(extended_indirect_jump_op, 0, 0, 0, 22'h151234, 4'h2, 0);
    run(indirect_call_op, 8'h00, 0, 8'h00, 22'h001234, 4'h2, 0);
    run(indirect_call_op, 8'h80, 0, 8'h00, 22'h001234, 4'h3, 0);
    run(extended_indirect_call_op, 8'h80, 0, 0, 22'h151234, 4'h3, 0);
    ax(1'b0, `ADDR_RETADDR, 32'h0);
    chk("retaddr", q, 32'h101);
    ax(1'b0, `ADDR_STATUS, 32'h0);
    chk("pushed", {30'h0, q[8:7]}, 32'h3);
    run(compare_skip_equal_op, 8'h00, 32'h3333, 0, 22'h102, 4'h2, 1);
    run(compare_skip_equal_op, 8'h00, 32'h3433, 0, 22'h101, 4'h1, 0);
    run(compare_skip_equal_op, 8'h40, 32'h3333, 0, 22'h103, 4'h3, 1);
    run(skip_reg_bit_clear_op, 8'h03, 0, 8'hFF, 22'h102, 4'h2, 1);
    run(skip_reg_bit_set_op, 8'h43, 32'h800, 0, 22'h103, 4'h3, 1);
    run(skip_reg_bit_set_op, 8'h03, 0, 8'h00, 22'h101, 4'h1, 0);
    run(skip_io_bit_clear_op, 8'h07, 0, 8'h00, 22'h101, 4'h2, 0);
    run(skip_io_bit_clear_op, 8'h00, 0, 8'h00, 22'h102, 4'h3, 1);
    run(skip_io_bit_set_op, 8'h47, 0, 8'h00, 22'h103, 4'h4, 1);
  endtask : t_jump_skip

  task t_branch;
    run(branch_flag_set_op, 8'h30, 32'h50000, 8'h40, 22'h106, 2, 1);
    run(branch_flag_clear_op, 8'h30, 32'h50000, 8'h40, 22'h101, 1, 0);
    run(branch_signed_ge_op, 0, 32'h50000, 8'h0C, 22'h106, 2, 1);
    run(branch_signed_ge_op, 0, 32'h50000, 8'h04, 22'h101, 1, 0);
    run(branch_signed_lt_op, 0, 32'h400000, 8'h04, 22'h0C1, 2, 1);
    run(branch_unsigned_ge_op, 0, 32'h50000, 8'h01, 22'h101, 1, 0);
    run(branch_unsigned_lt_op, 0, 32'h50000, 8'h01, 22'h106, 2, 1);
    run(branch_half_carry_set_op, 0, 32'h50000, 8'h20, 22'h106, 2, 1);
    run(branch_half_carry_clear_op, 0, 32'h50000, 8'h20, 22'h101, 1, 0);
    run(branch_overflow_set_op, 0, 32'h50000, 8'h00, 22'h101, 1, 0);
    run(branch_overflow_clear_op, 0, 32'h50000, 0, 22'h106, 2, 1);
    run(branch_irq_enabled_op, 0, 32'h50000, 8'h80, 22'h106, 2, 1);
    run(branch_irq_disabled_op, 0, 32'h50000, 8'h80, 22'h101, 1, 0);
    run(op_t'(5'h1F), 8'h00, 0, 8'h00, 22'h101, 4'h1, 0);
  endtask : t_branch

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset_map();
    t_alu();
    t_cipher();
    t_jump_skip();
    t_branch();
    finish_test();
  end
endmodule : test_cpu_alu_branch_execute
